// ===== common/iras_map.svh
// timing counts, register offsets and written values for the host controller
`ifndef IRAS_MAP_SVH
`define IRAS_MAP_SVH

`define IRAS_SYS_CLK_MHZ 250
`define IRAS_SCL_PERIOD_NS 1000
`define IRAS_QTR_CYCLES ((`IRAS_SCL_PERIOD_NS * `IRAS_SYS_CLK_MHZ + 3999) / 4000)
`define IRAS_POLL_PERIOD_US 100
`define IRAS_POLL_CYCLES (`IRAS_POLL_PERIOD_US * `IRAS_SYS_CLK_MHZ)

`define IRAS_CHAN_IDS {7'h1c, 7'h2c, 7'h5c, 7'h6c}
`define IRAS_KNOWN_REG 8'h25
`define IRAS_STATUS_REG 8'h02
`define IRAS_PLL_REG 8'h10
`define IRAS_GATE_REG 8'h11
`define IRAS_PLL_BYPASS_VAL 8'h08
`define IRAS_GATE_OFF_VAL 8'h01

`endif

// ===== common/iras_pkg.sv
// types shared by the host controller and its bit engine
package iras_pkg;

  typedef enum logic [1:0] {
    IRAS_OP_START = 2'h0,
    IRAS_OP_WRITE = 2'h1,
    IRAS_OP_STOP = 2'h2,
    IRAS_OP_READ = 2'h3
  } iras_op_t;

  typedef struct packed {
    iras_op_t op;
    logic [7:0] data;
    logic ack;
  } iras_bit_req_t;

  typedef struct packed {
    logic done;
    logic acked;
    logic [7:0] data;
  } iras_bit_rsp_t;

  typedef struct packed {
    logic rd;
    logic [1:0] chan;
    logic [7:0] reg_addr;
    logic [7:0] len;
  } iras_cmd_t;

  typedef enum logic [1:0] {IRAS_OK, IRAS_NACK_ID, IRAS_NACK_REG, IRAS_NACK_DATA} iras_err_t;
  typedef enum logic [1:0] {IRAS_SRC_USER, IRAS_SRC_INIT, IRAS_SRC_POLL} iras_src_t;

  typedef enum logic [1:0] {
    IRAS_INIT_READY = 2'h0,
    IRAS_INIT_PLL = 2'h1,
    IRAS_INIT_GATE = 2'h3,
    IRAS_INIT_RUN = 2'h2
  } iras_init_t;

  typedef enum logic [3:0] {
    IRAS_ST_IDLE = 4'h0,
    IRAS_ST_START = 4'h1,
    IRAS_ST_ID = 4'h3,
    IRAS_ST_REG = 4'h2,
    IRAS_ST_WDATA = 4'h6,
    IRAS_ST_RSTART = 4'h7,
    IRAS_ST_RID = 4'h5,
    IRAS_ST_RDATA = 4'h4,
    IRAS_ST_STOP = 4'hc
  } iras_state_t;

endpackage

// ===== hw/iras_bit.sv
// bit engine: start, stop, byte write and byte read on scl and sda
`timescale 1ns/1ps
`include "iras_map.svh"
module iras_bit #(
  parameter int QTR = `IRAS_QTR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic go,
  input wire iras_pkg::iras_bit_req_t req,
  output iras_pkg::iras_bit_rsp_t rsp,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  localparam int QW = $clog2(QTR + 1);

  logic [1:0] pin_raw;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_val;
  iras_pkg::iras_op_t op;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [QW-1:0] qcnt;
  logic [7:0] shreg;
  logic busy;
  logic ack_out;
  logic acked;
  logic done;

  assign pin_raw = {scl_i, sda_i};

  ////////////////////////////////////////////////////////////////////////////
  // three-stage pin synchronisers, value moves once stages two and three agree
  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        pin_s1[g] <= 1'b1;
        pin_s2[g] <= 1'b1;
        pin_s3[g] <= 1'b1;
        pin_val[g] <= 1'b1;
      end
      else
      begin
        pin_s1[g] <= pin_raw[g];
        pin_s2[g] <= pin_s1[g];
        pin_s3[g] <= pin_s2[g];
        if (pin_s2[g] == pin_s3[g])
          pin_val[g] <= pin_s3[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter-period sequencing; scl high in quarters 2 and 3
  wire is_data = op[0];
  wire hold = busy && ph[1] && !pin_val[1];
  wire qend = busy && !hold && (qcnt == QW'(QTR - 1));
  wire last = !is_data || (bitn == 4'h8);
  wire sample = qend && (ph == 2'h2) && is_data;
  wire sda_low = (op == iras_pkg::IRAS_OP_START) ? (ph == 2'h3) :      // [RULE_02]
                 (op == iras_pkg::IRAS_OP_STOP) ? (ph != 2'h3) :
                 (bitn == 4'h8) ? ((op == iras_pkg::IRAS_OP_READ) && ack_out) :  // [RULE_09] [RULE_10]
                 ((op == iras_pkg::IRAS_OP_WRITE) && !shreg[7]);

  assign rsp = '{done: done, acked: acked, data: shreg};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      op <= iras_pkg::IRAS_OP_START;
      ph <= 2'h0;
      bitn <= 4'h0;
      qcnt <= '0;
      shreg <= 8'h00;
      ack_out <= 1'b0;
      acked <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (go && !busy)
      begin
        busy <= 1'b1;
        op <= req.op;
        shreg <= req.data;
        ack_out <= req.ack;
        ph <= 2'h0;
        bitn <= 4'h0;
        qcnt <= '0;
      end
      else if (busy)
      begin
        qcnt <= (hold || qend) ? '0 : QW'(qcnt + 1'b1);
        if (sample && bitn != 4'h8 && op == iras_pkg::IRAS_OP_READ)
          shreg <= {shreg[6:0], pin_val[0]};
        if (sample && bitn == 4'h8 && op == iras_pkg::IRAS_OP_WRITE)
          acked <= !pin_val[0];
        if (qend)
        begin
          ph <= ph + 2'h1;
          if (ph == 2'h3 && last)
          begin
            busy <= 1'b0;
            done <= 1'b1;
          end
          else if (ph == 2'h3)
          begin
            bitn <= bitn + 4'h1;                                       // [RULE_01]
            if (op == iras_pkg::IRAS_OP_WRITE)
              shreg <= {shreg[6:0], 1'b1};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers; sda moves only in quarters 1 and 3, lines hold between ops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (busy)
    begin
      scl_oe_n <= ph[1];
      if (ph[0])
        sda_oe_n <= !sda_low;                                          // [RULE_01]
    end
  end

  a_sda_stable_high: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_01]
    (scl_oe_n && $past(scl_oe_n) && is_data) |-> $stable(sda_oe_n))
    else $error("sda moved while scl high during a data bit");

  a_cond_only_op: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_02]
    (scl_oe_n && $past(scl_oe_n) && $changed(sda_oe_n)) |-> !is_data)
    else $error("control condition raised outside start or stop");

  a_ack_driven: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_09]
    (busy && op == iras_pkg::IRAS_OP_READ && bitn == 4'h8 && ph[1] && ack_out) |-> !sda_oe_n)
    else $error("ack not driven low through ninth clock");

  a_nack_released: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_10]
    (busy && op == iras_pkg::IRAS_OP_READ && bitn == 4'h8 && ph[1] && !ack_out) |-> sda_oe_n)
    else $error("nack slot not left released");
endmodule

// ===== hw/iras_host.sv
// host controller that reads and writes the bridge registers over the two-wire link
// Summary of operation
// RULE_01: one bit per scl period; sda held steady while scl is high.
// RULE_02: sda changing while scl high is a start, repeated start or stop.
// RULE_03: with no transfer running both scl and sda are released high.
// RULE_04: write: start, id with write bit, ack, register, ack, data, ack, stop.
// RULE_05: slave nacks an invalid register address.
// RULE_06: burst write sends further bytes, each acked, ended by stop.
// RULE_07: read: register in write mode, repeated start, id with read bit, byte, nack, stop.
// RULE_08: burst read acks all bytes but the last, nacks the last, then stop.
// RULE_09: an ack pulls sda low before and through the ninth clock high.
// RULE_10: a nack leaves sda high through the ninth clock; marks a failed transfer.
// RULE_11: device initialises after reset and signals readiness on its interrupt line.
// RULE_12: polled host reads a known register until the expected value returns.
// RULE_13: polled host ignores the interrupt line and reads interrupt status periodically.
// RULE_14: device interrupt line is active-low open drain.
// RULE_15: host gates the clock of each unused channel.
// RULE_16: host disables and bypasses the internal pll for low power.
// RULE_17: each channel answers its own strap-selected slave id.
// RULE_18: bit after the 7-bit id is 1 for read, 0 for write.
// RULE_19: device advances the register address in bursts, except the fifo register.
`timescale 1ns/1ps
`include "iras_map.svh"
module iras_host #(
  parameter int QTR = `IRAS_QTR_CYCLES,
  parameter int POLL_CYCLES = `IRAS_POLL_CYCLES,
  parameter logic [27:0] CHAN_IDS = `IRAS_CHAN_IDS,
  parameter logic [7:0] KNOWN_VAL = 8'h5a  // arbitrary expected content
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic irq_n,
  input wire logic irq_mode,
  input wire logic [3:0] chan_in_use,
  input wire logic cmd_valid,
  input wire iras_pkg::iras_cmd_t cmd,
  output logic cmd_ready,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic resp_valid,
  output iras_pkg::iras_err_t resp_err,
  output logic dev_ready,
  output logic stat_valid,
  output logic [1:0] stat_chan,
  output logic [7:0] stat_data
);
  localparam int PW = $clog2(POLL_CYCLES + 1);

  iras_pkg::iras_state_t state;
  iras_pkg::iras_state_t next_state;
  iras_pkg::iras_err_t next_err;
  iras_pkg::iras_err_t t_err;
  iras_pkg::iras_src_t t_src;
  iras_pkg::iras_src_t l_src;
  iras_pkg::iras_init_t init_ph;
  iras_pkg::iras_bit_req_t bit_req;
  iras_pkg::iras_bit_rsp_t bit_rsp;
  iras_pkg::iras_op_t req_op;
  logic irq_s1;
  logic irq_s2;
  logic irq_s3;
  logic irq_low;
  logic wait_rsp;
  logic bit_go;
  logic t_rd;
  logic [1:0] t_chan;
  logic [7:0] t_reg;
  logic [7:0] t_left;
  logic [7:0] t_val;
  logic [7:0] cur_wdata;
  logic known_ok;
  logic [1:0] gate_idx;
  logic [1:0] sweep_chan;
  logic [PW-1:0] poll_cnt;
  logic poll_due;
  logic l_go;
  logic l_rd;
  logic l_take;
  logic [1:0] l_chan;
  logic [7:0] l_reg;
  logic [7:0] l_len;
  logic [7:0] l_val;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt line sync; low means the device is asserting
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
      irq_s3 <= 1'b1;
      irq_low <= 1'b0;
    end
    else
    begin
      irq_s1 <= irq_n;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      if (irq_s2 == irq_s3)
        irq_low <= !irq_s3;                                            // [RULE_14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire [6:0] dev_id = CHAN_IDS[7 * t_chan +: 7];                       // [RULE_17]
  wire in_idle = state == iras_pkg::IRAS_ST_IDLE;
  wire rsp_done = bit_rsp.done;
  wire rsp_ack = bit_rsp.acked;
  wire user_wr = (state == iras_pkg::IRAS_ST_WDATA) && (t_src == iras_pkg::IRAS_SRC_USER);
  wire issue = !wait_rsp && !in_idle && (!user_wr || wr_valid);
  wire launch = in_idle && l_go;
  wire finish = (state == iras_pkg::IRAS_ST_STOP) && rsp_done;
  wire rdata_done = (state == iras_pkg::IRAS_ST_RDATA) && rsp_done;
  wire poll_tick = poll_cnt == PW'(POLL_CYCLES - 1);
  wire poll_trig = irq_mode ? irq_low : poll_due;                      // [RULE_13]
  wire ready_step = (in_idle && init_ph == iras_pkg::IRAS_INIT_READY && irq_mode && irq_low) ||  // [RULE_11]
                    (finish && init_ph == iras_pkg::IRAS_INIT_READY && known_ok);  // [RULE_12]
  wire gate_step = init_ph == iras_pkg::IRAS_INIT_GATE &&
                   ((in_idle && chan_in_use[gate_idx]) || finish);

  assign req_op = (state == iras_pkg::IRAS_ST_START || state == iras_pkg::IRAS_ST_RSTART) ?
                  iras_pkg::IRAS_OP_START :                            // [RULE_02]
                  (state == iras_pkg::IRAS_ST_STOP) ? iras_pkg::IRAS_OP_STOP :
                  (state == iras_pkg::IRAS_ST_RDATA) ? iras_pkg::IRAS_OP_READ : iras_pkg::IRAS_OP_WRITE;
  assign bit_req.op = req_op;
  assign bit_req.data = (state == iras_pkg::IRAS_ST_ID) ? {dev_id, 1'b0} :      // [RULE_18]
                        (state == iras_pkg::IRAS_ST_RID) ? {dev_id, 1'b1} :
                        (state == iras_pkg::IRAS_ST_REG) ? t_reg : cur_wdata;
  assign bit_req.ack = t_left != 8'h00;                                // [RULE_08]

  ////////////////////////////////////////////////////////////////////////////
  // choose the next transaction: init steps, status sweep, then user work
  always_comb
  begin
    l_go = 1'b0;
    l_take = 1'b0;
    l_src = iras_pkg::IRAS_SRC_INIT;
    l_rd = 1'b1;
    l_chan = 2'h0;
    l_reg = `IRAS_KNOWN_REG;
    l_len = 8'h00;
    l_val = 8'h00;
    case (init_ph)
      iras_pkg::IRAS_INIT_READY:
        l_go = !irq_mode && poll_due;                                  // [RULE_12]
      iras_pkg::IRAS_INIT_PLL:
      begin
        l_go = 1'b1;
        l_rd = 1'b0;
        l_reg = `IRAS_PLL_REG;
        l_val = `IRAS_PLL_BYPASS_VAL;                                  // [RULE_16]
      end
      iras_pkg::IRAS_INIT_GATE:
      begin
        l_go = !chan_in_use[gate_idx];                                 // [RULE_15]
        l_rd = 1'b0;
        l_chan = gate_idx;
        l_reg = `IRAS_GATE_REG;
        l_val = `IRAS_GATE_OFF_VAL;
      end
      default:
      begin
        if (sweep_chan != 2'h0 || poll_trig)
        begin
          l_go = 1'b1;
          l_src = iras_pkg::IRAS_SRC_POLL;
          l_chan = sweep_chan;
          l_reg = `IRAS_STATUS_REG;
        end
        else if (cmd_valid)
        begin
          l_go = 1'b1;
          l_take = 1'b1;
          l_src = iras_pkg::IRAS_SRC_USER;
          l_rd = cmd.rd;
          l_chan = cmd.chan;
          l_reg = cmd.reg_addr;
          l_len = cmd.len;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequence, moved on at each completed bit-engine operation
  always_comb
  begin
    next_state = iras_pkg::IRAS_ST_IDLE;
    next_err = t_err;
    case (state)
      iras_pkg::IRAS_ST_START:
        next_state = iras_pkg::IRAS_ST_ID;
      iras_pkg::IRAS_ST_ID:
      begin
        next_state = rsp_ack ? iras_pkg::IRAS_ST_REG : iras_pkg::IRAS_ST_STOP;  // [RULE_04]
        next_err = rsp_ack ? t_err : iras_pkg::IRAS_NACK_ID;           // [RULE_10]
      end
      iras_pkg::IRAS_ST_REG:
      begin
        next_state = !rsp_ack ? iras_pkg::IRAS_ST_STOP :               // [RULE_05]
                     t_rd ? iras_pkg::IRAS_ST_RSTART : iras_pkg::IRAS_ST_WDATA;  // [RULE_07]
        next_err = rsp_ack ? t_err : iras_pkg::IRAS_NACK_REG;
      end
      iras_pkg::IRAS_ST_WDATA:
      begin
        next_state = (!rsp_ack || t_left == 8'h00) ? iras_pkg::IRAS_ST_STOP :   // [RULE_06]
                     iras_pkg::IRAS_ST_WDATA;
        next_err = rsp_ack ? t_err : iras_pkg::IRAS_NACK_DATA;
      end
      iras_pkg::IRAS_ST_RSTART:
        next_state = iras_pkg::IRAS_ST_RID;
      iras_pkg::IRAS_ST_RID:
      begin
        next_state = rsp_ack ? iras_pkg::IRAS_ST_RDATA : iras_pkg::IRAS_ST_STOP;
        next_err = rsp_ack ? t_err : iras_pkg::IRAS_NACK_ID;
      end
      iras_pkg::IRAS_ST_RDATA:
        next_state = (t_left == 8'h00) ? iras_pkg::IRAS_ST_STOP : iras_pkg::IRAS_ST_RDATA;  // [RULE_08]
      default:
        next_state = iras_pkg::IRAS_ST_IDLE;                           // [RULE_03]
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= iras_pkg::IRAS_ST_IDLE;
      t_err <= iras_pkg::IRAS_OK;
      t_src <= iras_pkg::IRAS_SRC_INIT;
      t_rd <= 1'b0;
      t_chan <= 2'h0;
      t_reg <= 8'h00;
      t_left <= 8'h00;
      t_val <= 8'h00;
      cur_wdata <= 8'h00;
      wait_rsp <= 1'b0;
      bit_go <= 1'b0;
    end
    else
    begin
      bit_go <= 1'b0;
      if (launch)
      begin
        state <= iras_pkg::IRAS_ST_START;
        t_err <= iras_pkg::IRAS_OK;
        t_src <= l_src;
        t_rd <= l_rd;
        t_chan <= l_chan;
        t_reg <= l_reg;
        t_left <= l_len;
        t_val <= l_val;
      end
      else if (issue)
      begin
        bit_go <= 1'b1;
        wait_rsp <= 1'b1;
        cur_wdata <= user_wr ? wr_data : t_val;
      end
      else if (rsp_done)
      begin
        wait_rsp <= 1'b0;
        state <= next_state;
        t_err <= next_err;
        if ((state == iras_pkg::IRAS_ST_WDATA || state == iras_pkg::IRAS_ST_RDATA) && t_left != 8'h00)
          t_left <= t_left - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user handshakes, read deliveries and status results
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_ready <= 1'b0;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      resp_valid <= 1'b0;
      resp_err <= iras_pkg::IRAS_OK;
      stat_valid <= 1'b0;
      stat_chan <= 2'h0;
      stat_data <= 8'h00;
      known_ok <= 1'b0;
    end
    else
    begin
      cmd_ready <= launch && l_take;
      wr_ready <= issue && user_wr;
      rd_valid <= rdata_done && t_src == iras_pkg::IRAS_SRC_USER;
      stat_valid <= rdata_done && t_src == iras_pkg::IRAS_SRC_POLL;
      resp_valid <= finish && t_src == iras_pkg::IRAS_SRC_USER;
      if (rdata_done)
      begin
        rd_data <= bit_rsp.data;
        stat_data <= bit_rsp.data;
        stat_chan <= t_chan;
      end
      if (finish)
        resp_err <= t_err;
      if (launch)
        known_ok <= 1'b0;
      else if (rdata_done && t_src == iras_pkg::IRAS_SRC_INIT)
        known_ok <= bit_rsp.data == KNOWN_VAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // startup phases, poll timer and channel sweep
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_ph <= iras_pkg::IRAS_INIT_READY;
      gate_idx <= 2'h0;
      dev_ready <= 1'b0;
      sweep_chan <= 2'h0;
      poll_cnt <= '0;
      poll_due <= 1'b0;
    end
    else
    begin
      poll_cnt <= poll_tick ? '0 : PW'(poll_cnt + 1'b1);
      poll_due <= poll_tick || (poll_due && !(launch && l_src != iras_pkg::IRAS_SRC_USER));
      dev_ready <= init_ph == iras_pkg::IRAS_INIT_RUN;
      if (ready_step)
        init_ph <= iras_pkg::IRAS_INIT_PLL;
      else if (finish && init_ph == iras_pkg::IRAS_INIT_PLL)
        init_ph <= iras_pkg::IRAS_INIT_GATE;
      else if (gate_step && gate_idx == 2'h3)
        init_ph <= iras_pkg::IRAS_INIT_RUN;
      if (gate_step)
        gate_idx <= gate_idx + 2'h1;
      if (finish && t_src == iras_pkg::IRAS_SRC_POLL)
        sweep_chan <= sweep_chan + 2'h1;
    end
  end

  iras_bit #(
    .QTR(QTR)
  ) u_bit (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .go(bit_go),
    .req(bit_req),
    .rsp(bit_rsp),
    .scl_i(scl_i),
    .scl_o(scl_o),
    .scl_oe_n(scl_oe_n),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_idle_release: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_03]
    in_idle |-> (scl_oe_n && sda_oe_n))
    else $error("bus not released while idle");

  a_id_write_bit: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_18]
    (bit_go && state == iras_pkg::IRAS_ST_ID) |-> !bit_req.data[0] && bit_req.data[7:1] == dev_id)
    else $error("address phase without write bit");

  a_id_read_bit: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_18]
    (bit_go && state == iras_pkg::IRAS_ST_RID) |-> bit_req.data[0])
    else $error("read address phase without read bit");

  a_id_then_reg: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_04]
    (rsp_done && state == iras_pkg::IRAS_ST_ID && rsp_ack) |=> state == iras_pkg::IRAS_ST_REG ##1 bit_go)
    else $error("register byte did not follow acked id");

  a_reg_nack_stop: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_05]
    (rsp_done && state == iras_pkg::IRAS_ST_REG && !rsp_ack) |=> state == iras_pkg::IRAS_ST_STOP
      && t_err == iras_pkg::IRAS_NACK_REG)
    else $error("register nack not ended with stop");

  a_burst_stop: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_06]
    (rsp_done && state == iras_pkg::IRAS_ST_WDATA && rsp_ack && t_left == 8'h00) |=>
      state == iras_pkg::IRAS_ST_STOP)
    else $error("burst write did not stop after last byte");

  a_read_restart: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_07]
    (rsp_done && state == iras_pkg::IRAS_ST_REG && rsp_ack && t_rd) |=> state == iras_pkg::IRAS_ST_RSTART)
    else $error("read lacks repeated start");

  a_last_nack: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_08]
    (rsp_done && state == iras_pkg::IRAS_ST_RDATA && t_left == 8'h00) |=> state == iras_pkg::IRAS_ST_STOP
      && !u_bit.ack_out)
    else $error("last read byte not nacked before stop");

  a_polled_no_irq: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_13]
    (launch && l_src == iras_pkg::IRAS_SRC_POLL && sweep_chan == 2'h0) |-> (irq_mode || poll_due))
    else $error("polled sweep started by interrupt line");
endmodule

// ===== dv/iras_dev.sv
// behavioural bridge model answering the host on scl and sda
`timescale 1ns/1ps
`include "iras_map.svh"
module iras_dev #(
  parameter logic [27:0] IDS = `IRAS_CHAN_IDS,
  parameter logic [7:0] KNOWN = 8'h5a // arbitrary expected content
) (
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  input wire logic irq_set,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic irq_n
);
  logic [7:0] mem [1024];
  logic [7:0] sh, tx, ptr;
  logic [3:0] cnt;
  logic [1:0] ch, ph;
  logic act, rd, ok, pend, rdy;
  int i;
  assign irq_n = !pend;
  // status contents arbitrary, one per channel
  initial
  begin
    {act, pend, rdy, scl_oe_n, sda_oe_n} = 5'h03;
    for (i = 0; i < 1024; i++) mem[i] = (i[7:0] == 8'h25) ? KNOWN : (i[7:0] == 8'h02) ? 8'h30 + i[9:8] : 8'h00;
  end
  always @(negedge rstn) {act, pend, rdy, sda_oe_n} = 4'h1;
  always @(posedge rstn) #2000 {rdy, pend} = 2'h3;
  always @(posedge irq_set) pend = 1'h1;
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge sda) if (scl) {act, rd, ph, cnt} = 8'h80;
  always @(posedge sda) if (scl) {act, sda_oe_n} = 2'h1;
  always @(posedge scl) if (act)
  begin
    if (cnt < 8) sh = {sh[6:0], sda};
    // master ack slot only; own ack after the read id drives sda low
    else if (rd && ph == 2 && sda_oe_n) {act, ptr} = {!sda, ptr + (ptr != 0)};
    cnt = cnt + 1;
  end
  // sda only moves while scl is low
  always @(negedge scl) if (act)
  begin
    if (cnt == 8 && !(rd && ph == 2))
    begin
      ok = (ph == 1) ? !sh[7] : (ph == 2);
      for (i = 0; i < 4; i++) if (ph == 0 && IDS[7 * i +: 7] == sh[7:1]) {ok, ch} = {1'h1, i[1:0]};
      if (ph == 2) mem[{ch, ptr}] = sh;
      if (ph == 2) ptr = ptr + (ptr != 0);
      if (ph == 1) ptr = sh;
      if (ph == 0) rd = sh[0];
      ph = (ph == 0 && !sh[0]) ? 2'h1 : 2'h2;
      {act, sda_oe_n} = {ok, !ok};
    end
    else
    begin
      cnt = (cnt == 9) ? 4'h0 : cnt;
      if (rd && ph == 2 && cnt == 0) {tx, pend} = {(rdy || ptr != 8'h25) ? mem[{ch, ptr}] : 8'h00, pend && ptr != 8'h02};
      sda_oe_n = (rd && ph == 2 && cnt < 8) ? tx[7 - cnt] : 1'h1;
    end
  end
  // slow answers stretch each low phase
  always @(negedge scl) if (act && slow)
  begin
    scl_oe_n = 1'h0;
    #100 scl_oe_n = 1'h1;
  end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the host controller against the bridge model
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    iras_pkg::iras_cmd_t c;
    logic [15:0] w;
    logic [1:0] e;
    logic [15:0] r;
  } iras_row_t;
  logic sys_clk, rstn, irq_mode, cmd_valid, wr_valid, irq_set, slow;
  logic [3:0] chan_in_use;
  logic [7:0] wr_data;
  logic [15:0] got, w;
  iras_pkg::iras_cmd_t cmd;
  wire logic scl_oe_n, sda_oe_n, dev_scl_oe_n, dev_sda_oe_n, irq_n, cmd_ready, wr_ready, rd_valid, resp_valid;
  wire logic dev_ready, stat_valid;
  wire logic [7:0] rd_data, stat_data;
  wire logic [1:0] stat_chan;
  wire iras_pkg::iras_err_t resp_err;
  wire logic scl = scl_oe_n & dev_scl_oe_n;
  wire logic sda = sda_oe_n & dev_sda_oe_n;
  int n_mismatch, cmp_count, cyc, k;
  iras_row_t rows [8] = '{
    {1'h0, 2'h1, 8'h40, 8'h01, 16'ha55a, 2'h0, 16'h0000},
    {1'h1, 2'h1, 8'h40, 8'h01, 16'h0000, 2'h0, 16'ha55a},
    {1'h1, 2'h0, 8'h25, 8'h00, 16'h0000, 2'h0, 16'h005a},
    {1'h1, 2'h0, 8'h10, 8'h00, 16'h0000, 2'h0, 16'h0008},
    {1'h1, 2'h2, 8'h11, 8'h00, 16'h0000, 2'h0, 16'h0001},
    {1'h1, 2'h1, 8'h11, 8'h00, 16'h0000, 2'h0, 16'h0000},
    {1'h0, 2'h0, 8'h90, 8'h00, 16'h1100, 2'h2, 16'h0000},
    {1'h1, 2'h3, 8'h25, 8'h00, 16'h0000, 2'h1, 16'h0000}};
  iras_host #(.QTR(4), .POLL_CYCLES(200), .CHAN_IDS({7'h1d, 7'h2c, 7'h5c, 7'h6c})) dut (
    .sys_clk(sys_clk), .rstn(rstn), .scl_i(scl), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(),
    .sda_oe_n(sda_oe_n), .irq_n(irq_n), .irq_mode(irq_mode), .chan_in_use(chan_in_use), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .resp_valid(resp_valid), .resp_err(resp_err), .dev_ready(dev_ready),
    .stat_valid(stat_valid), .stat_chan(stat_chan), .stat_data(stat_data));
  iras_dev model (.rstn(rstn), .scl(scl), .sda(sda), .slow(slow), .irq_set(irq_set),
    .scl_oe_n(dev_scl_oe_n), .sda_oe_n(dev_sda_oe_n), .irq_n(irq_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one command; write bytes follow each wr_ready, read bytes collect
  task automatic xfer(input iras_row_t r);
    {cmd, w, got} = {r.c, r.w, 16'h0000};
    {cmd_valid, wr_valid, wr_data} = {1'h1, !r.c.rd, r.w[15:8]};
    do tick; while (cmd_ready !== 1'h1);
    cmd_valid = 1'h0;
    do
    begin
      tick;
      if (rd_valid === 1'h1) got = {got[7:0], rd_data};
      if (wr_ready === 1'h1) {w, wr_data} = {w << 8, w[7:0]};
    end
    while (resp_valid !== 1'h1);
    wr_valid = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial
  begin
    {sys_clk, rstn, irq_mode, cmd_valid, wr_valid, irq_set, slow} = 7'h10;
    {chan_in_use, wr_data, cmd} = {4'hb, 8'h00, 19'h0_0000};
    repeat (4) tick;
    rstn = 1'h1;
    #1000 check(dev_ready, 1'h0);
    while (dev_ready !== 1'h1) tick;
    for (k = 0; k < 8; k++)
    begin
      xfer(rows[k]);
      check(resp_err, rows[k].e);
      check(got, rows[k].r);
      $display("test %0d done", k);
    end
    irq_set = 1'h1;
    while (!(stat_valid === 1'h1 && stat_chan === 2'h1)) tick;
    check(stat_data, 8'h31);
    irq_set = 1'h0;
    repeat (3000) tick;
    check({scl, sda}, 2'h3);
    check({dut.scl_o, dut.sda_o}, 2'h0);
    $display("test irq done");
    {rstn, irq_mode, slow} = 3'h1;
    repeat (4) tick;
    rstn = 1'h1;
    #1500 check(dev_ready, 1'h0);
    while (dev_ready !== 1'h1) tick;
    while (!(stat_valid === 1'h1 && stat_chan === 2'h2)) tick;
    check(stat_data, 8'h32);
    $display("test polled done");
    print_verdict;
  end
endmodule
